//--- core/usp_pkg.sv
// Package for the serial port status, parity, timeguard and idle time-out logic.
// Assumes a single system clock; baud timing comes in as a one-cycle bit tick.
package usp_pkg;
    // Parity select encodings
    localparam logic [2:0] PAR_EVEN  = 3'h0;
    localparam logic [2:0] PAR_ODD   = 3'h1;
    localparam logic [2:0] PAR_SPACE = 3'h2;
    localparam logic [2:0] PAR_MARK  = 3'h3;
    localparam logic [2:0] PAR_NONE  = 3'h4;
    localparam logic [2:0] PAR_MD0   = 3'h6;
    localparam logic [2:0] PAR_MD1   = 3'h7;
    // Field widths
    localparam int DATA_W  = 8;
    localparam int GUARD_W = 8;
    localparam int IDLE_W  = 16;
    localparam int FIFO_DEPTH = 16;
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [IDLE_W-1:0] IDLE_RST = 16'h0000;
    localparam logic [GUARD_W-1:0] GUARD_RST = 8'h00;
    // Frame length in ticks after the start bit, with parity
    localparam logic [3:0] TX_BITS_BASE = 4'ha;
    typedef enum logic [3:0]
    {
        TX_IDLE  = 4'h1,
        TX_SHIFT = 4'h2,
        TX_GUARD = 4'h4,
        TX_LOAD  = 4'h8
    } usp_tx_state_t;
endpackage

//--- core/usp_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module usp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Honest full and empty from the occupancy count
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_reg <= AW'(wptr_reg + 1'b1);
            end
            if (pop)
            begin
                rptr_reg <= AW'(rptr_reg + 1'b1);
            end
            count_reg <= (AW+1)'(count_reg + push - pop);
        end
    end
endmodule

//--- core/usp_core.sv
// Serial port core: receive holding and status, parity, multidrop, transmit
// timeguard and receiver idle time-out.
// Assumes the framer supplies each character with its parity bit, and a
// one-cycle bit_tick per bit period.
// Function
// - Completed character loads holding, raises ready
// - Completion while ready sets overrun, overwrites
// - Overrun clears only by clear-status command
// - Even parity: generate and check
// - Odd parity: generate and check
// - Mark parity sends one, errors on zero
// - Space parity sends zero, errors on one
// - No parity: no bit, no error
// - Parity error sticky until clear-status
// - Parity select six or seven means multidrop
// - Multidrop: data parity zero, address one
// - Multidrop receive: high parity flags error
// - Send-address marks next written byte
// - Guard length bit periods of idle high
// - Holding-free rises at next start bit
// - All-done low until guard ends
// - Zero idle limit disables time-out
// - Counter loads limit, counts bits, times out
// - Arm command freezes counter until character
// - Reload command restarts countdown immediately
`timescale 1ns/100ps
module usp_core
(
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          resetn,
    // Configuration
    input  wire logic [2:0]                    parity_select,
    input  wire logic [usp_pkg::GUARD_W-1:0]   guard_length,
    input  wire logic [usp_pkg::IDLE_W-1:0]    idle_limit,
    // Commands, one-cycle pulses
    input  wire logic                          clear_status_cmd,
    input  wire logic                          send_address_cmd,
    input  wire logic                          arm_on_next_char_cmd,
    input  wire logic                          reload_restart_cmd,
    // Bit period tick
    input  wire logic                          bit_tick,
    // Received character from the framer
    input  wire logic                          rx_done,
    input  wire logic [usp_pkg::DATA_W-1:0]    rx_data,
    input  wire logic                          rx_parity_bit,
    input  wire logic                          rx_read,
    // Transmit holding write
    input  wire logic                          tx_write,
    input  wire logic [usp_pkg::DATA_W-1:0]    tx_data,
    // Status
    output logic [usp_pkg::DATA_W-1:0]         receive_holding_reg,
    output logic                               rx_char_ready,
    output logic                               overrun_flag,
    output logic                               parity_error_flag,
    output logic                               timeout_flag,
    output logic                               tx_holding_free,
    output logic                               tx_all_done,
    output logic                               tx_line
);
    logic                          md_mode;
    logic                          rx_par_err;
    logic                          addr_pend_reg;
    logic                          fifo_in_ready;
    logic                          fifo_out_valid;
    logic                          fifo_out_ready;
    logic [usp_pkg::DATA_W:0]      fifo_out_data;
    usp_pkg::usp_tx_state_t        tx_state_reg;
    logic [10:0]                   shift_reg;
    logic [3:0]                    bit_cnt_reg;
    logic [usp_pkg::GUARD_W-1:0]   guard_cnt_reg;
    logic [usp_pkg::IDLE_W-1:0]    idle_cnt_reg;
    logic                          idle_run_reg;
    logic [4:0]                    tx_fill_reg;
    logic [4:0]                    tx_fill_next;

    // Parity bit for a given mode and payload; used by both directions
    function automatic logic par_bit(input logic [2:0] sel, input logic [usp_pkg::DATA_W-1:0] d,
                                     input logic addr);
        case (sel)
            usp_pkg::PAR_EVEN:  par_bit = ^d;
            usp_pkg::PAR_ODD:   par_bit = ~(^d);
            usp_pkg::PAR_MARK:  par_bit = 1'b1;
            usp_pkg::PAR_SPACE: par_bit = 1'b0;
            usp_pkg::PAR_MD0,
            usp_pkg::PAR_MD1:   par_bit = addr;
            default:            par_bit = 1'b0;
        endcase
    endfunction

    function automatic logic has_parity(input logic [2:0] sel);
        has_parity = (sel != usp_pkg::PAR_NONE) && (sel != 3'h5);
    endfunction

    assign md_mode = (parity_select == usp_pkg::PAR_MD0) || (parity_select == usp_pkg::PAR_MD1);

    // Receive check; multidrop flags high parity
    assign rx_par_err = !has_parity(parity_select) ? 1'b0 :
                        md_mode ? rx_parity_bit :
                        (rx_parity_bit != par_bit(parity_select, rx_data, 1'b0));

    // Receive holding register always takes the newest character
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            receive_holding_reg <= usp_pkg::DATA_RST;
        end
        else if (rx_done)
        begin
            receive_holding_reg <= rx_data;
        end
    end

    // Ready flag; a completion in the same cycle as a read wins
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            rx_char_ready <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_char_ready <= 1'b1;
        end
        else if (rx_read)
        begin
            rx_char_ready <= 1'b0;
        end
    end

    // Sticky error flags; set beats clear
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            overrun_flag      <= 1'b0;
            parity_error_flag <= 1'b0;
        end
        else
        begin
            if (rx_done && rx_char_ready)
            begin
                overrun_flag <= 1'b1;
            end
            else if (clear_status_cmd)
            begin
                overrun_flag <= 1'b0;
            end
            if (rx_done && rx_par_err)
            begin
                parity_error_flag <= 1'b1;
            end
            else if (clear_status_cmd)
            begin
                parity_error_flag <= 1'b0;
            end
        end
    end

    // Address mark waits for the next accepted byte
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            addr_pend_reg <= 1'b0;
        end
        else if (send_address_cmd)
        begin
            addr_pend_reg <= 1'b1;
        end
        else if (tx_write && fifo_in_ready)
        begin
            addr_pend_reg <= 1'b0;
        end
    end

    // Holding buffer; the address mark travels with each byte
    usp_fifo #(
        .WIDTH (usp_pkg::DATA_W + 1),
        .DEPTH (usp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (tx_write),
        .in_ready  (fifo_in_ready),
        .in_data   ({addr_pend_reg | send_address_cmd, tx_data}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Drain at a start bit
    assign fifo_out_ready = (tx_state_reg == usp_pkg::TX_IDLE) && bit_tick;

    // Transmitter: start, data, optional parity, stop, then guard
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            tx_state_reg  <= usp_pkg::TX_IDLE;
            shift_reg     <= '1;
            bit_cnt_reg   <= '0;
            guard_cnt_reg <= usp_pkg::GUARD_RST;
            tx_line       <= 1'b1;
        end
        else
        begin
            case (tx_state_reg)
                usp_pkg::TX_IDLE:
                begin
                    tx_line <= 1'b1;
                    if (bit_tick && fifo_out_valid)
                    begin
                        // Start bit goes out now; payload LSB first
                        tx_line     <= 1'b0;
                        shift_reg   <= {1'b1, has_parity(parity_select) ?
                                        par_bit(parity_select, fifo_out_data[usp_pkg::DATA_W-1:0],
                                                fifo_out_data[usp_pkg::DATA_W]) : 1'b1,
                                        fifo_out_data[usp_pkg::DATA_W-1:0], 1'b0};
                        bit_cnt_reg <= has_parity(parity_select) ? usp_pkg::TX_BITS_BASE :
                                       4'(usp_pkg::TX_BITS_BASE - 4'h1);
                        tx_state_reg <= usp_pkg::TX_SHIFT;
                    end
                end
                usp_pkg::TX_SHIFT:
                begin
                    if (bit_tick)
                    begin
                        if (bit_cnt_reg == 4'h1)
                        begin
                            tx_line       <= 1'b1;
                            guard_cnt_reg <= guard_length;
                            tx_state_reg  <= (guard_length == usp_pkg::GUARD_RST) ?
                                             usp_pkg::TX_IDLE : usp_pkg::TX_GUARD;
                        end
                        else
                        begin
                            shift_reg   <= {1'b1, shift_reg[10:1]};
                            tx_line     <= shift_reg[1];
                            bit_cnt_reg <= 4'(bit_cnt_reg - 4'h1);
                        end
                    end
                end
                usp_pkg::TX_GUARD:
                begin
                    tx_line <= 1'b1;
                    if (bit_tick)
                    begin
                        guard_cnt_reg <= usp_pkg::GUARD_W'(guard_cnt_reg - 1'b1);
                        if (guard_cnt_reg == 8'h01)
                        begin
                            tx_state_reg <= usp_pkg::TX_IDLE;
                        end
                    end
                end
                default:
                begin
                    tx_state_reg <= usp_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // Own fill count: free flag shows the state after this edge
    assign tx_fill_next = 5'(tx_fill_reg + (tx_write && fifo_in_ready) - (fifo_out_valid && fifo_out_ready));

    // Transmit status: free only while the buffer has room; busy through guard
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            tx_holding_free <= 1'b0;
            tx_all_done     <= 1'b0;
            tx_fill_reg     <= '0;
        end
        else
        begin
            tx_fill_reg     <= tx_fill_next;
            tx_holding_free <= (tx_fill_next != 5'(usp_pkg::FIFO_DEPTH));
            tx_all_done     <= !fifo_out_valid && !tx_write && (tx_state_reg == usp_pkg::TX_IDLE);
        end
    end

    // Idle time-out counter, ticking once per bit period
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            idle_cnt_reg <= usp_pkg::IDLE_RST;
            idle_run_reg <= 1'b0;
            timeout_flag <= 1'b0;
        end
        else if (idle_limit == usp_pkg::IDLE_RST)
        begin
            idle_run_reg <= 1'b0;
            timeout_flag <= 1'b0;
        end
        else
        begin
            if (reload_restart_cmd)
            begin
                idle_cnt_reg <= idle_limit;
                idle_run_reg <= 1'b1;
            end
            else if (arm_on_next_char_cmd)
            begin
                idle_run_reg <= 1'b0;
            end
            else if (rx_done)
            begin
                idle_cnt_reg <= idle_limit;
                idle_run_reg <= 1'b1;
            end
            else if (idle_run_reg && bit_tick)
            begin
                idle_cnt_reg <= usp_pkg::IDLE_W'(idle_cnt_reg - 1'b1);
                if (idle_cnt_reg == 16'h0001)
                begin
                    idle_run_reg <= 1'b0;
                end
            end
            // Expiry beats an arm command in the same cycle; a reload or a character in that cycle wins over it
            if (idle_run_reg && bit_tick && idle_cnt_reg == 16'h0001 && !rx_done && !reload_restart_cmd)
            begin
                timeout_flag <= 1'b1;
            end
            else if (arm_on_next_char_cmd || reload_restart_cmd)
            begin
                timeout_flag <= 1'b0;
            end
        end
    end

    // Assertions
    a_overrun_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_done && rx_char_ready |=> overrun_flag) else $error("overrun not set");
    a_overrun_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        overrun_flag && !clear_status_cmd |=> overrun_flag) else $error("overrun dropped");
    a_ready_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_done |=> rx_char_ready && receive_holding_reg == $past(rx_data)) else $error("no load");
    a_parity_none: assert property (@(posedge clk_sys) disable iff (!resetn)
        parity_select == usp_pkg::PAR_NONE && !parity_error_flag && !clear_status_cmd
        |=> !parity_error_flag) else $error("parity error without parity");
    a_parity_mark: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_done && parity_select == usp_pkg::PAR_MARK && !rx_parity_bit |=> parity_error_flag)
        else $error("mark parity miss");
    a_md_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_done && md_mode && rx_parity_bit |=> parity_error_flag) else $error("address not flagged");
    a_timeout_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        idle_limit == usp_pkg::IDLE_RST |=> !timeout_flag) else $error("timeout while disabled");
    a_timeout_clr: assert property (@(posedge clk_sys) disable iff (!resetn)
        idle_limit != usp_pkg::IDLE_RST && reload_restart_cmd |=> !timeout_flag && idle_cnt_reg == $past(idle_limit))
        else $error("reload failed");
    a_guard_high: assert property (@(posedge clk_sys) disable iff (!resetn)
        tx_state_reg == usp_pkg::TX_GUARD |=> tx_line) else $error("line low in guard");
    a_done_guard: assert property (@(posedge clk_sys) disable iff (!resetn)
        tx_state_reg == usp_pkg::TX_GUARD |=> !tx_all_done) else $error("done during guard");
endmodule

//--- test/usp_remote_model.sv
// Remote serial device: makes the bit tick and decodes frames seen on tx_line.
// Assumes the core moves tx_line just after each tick, LSB first.
`timescale 1ns/100ps
module usp_remote_model #(
    parameter int TICK_DIV = 4
)
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Line and format
    input  wire logic [2:0] parity_select,
    input  wire logic       tx_line,
    output logic            bit_tick,
    // Decoded frames
    output logic            cap_valid,
    output logic [7:0]      cap_data,
    output logic            cap_par,
    output logic [7:0]      cap_gap
);
    int unsigned div_cnt = 0;
    int unsigned bit_idx;
    logic [7:0]  idle_cnt;
    logic        par_on;

    // Tick moves on the falling edge so the core samples it settled
    always @(negedge clk_sys)
    begin
        div_cnt  = (div_cnt + 1) % TICK_DIV;
        bit_tick = (div_cnt == 0);
    end

    // Parity slot present unless parity is off
    assign par_on = (parity_select[2:1] != 2'b10);

    // One sample per tick: start, 8 data, optional parity, stop
    always @(posedge clk_sys)
    begin
        cap_valid <= 1'b0;
        if (!resetn)
        begin
            bit_idx  <= 0;
            idle_cnt <= 8'hff;
        end
        else if (bit_tick)
        begin
            if (bit_idx == 0)
            begin
                if (!tx_line)
                begin
                    bit_idx <= 1;
                    cap_gap <= idle_cnt; // High samples since the last stop
                end
                else if (idle_cnt != 8'hff)
                    idle_cnt <= idle_cnt + 8'h01;
            end
            else if (bit_idx <= 8)
            begin
                cap_data <= {tx_line, cap_data[7:1]};
                bit_idx  <= bit_idx + 1;
            end
            else if (bit_idx == 9 && par_on)
            begin
                cap_par <= tx_line;
                bit_idx <= 10;
            end
            else
            begin
                cap_valid <= tx_line; // A low stop bit is not a frame
                bit_idx   <= 0;
                idle_cnt  <= 8'h00;
            end
        end
    end
endmodule

//--- test/usp_core_tb_top.sv
// Self-checking bench for the serial port core: receive status, parity,
// multidrop, timeguard with the transmit buffer, and idle time-out.
// Assumes the remote model makes a bit tick every TICK_DIV cycles.
`timescale 1ns/100ps
module usp_core_tb_top;
    localparam int TICK_DIV = 4;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [2:0]  parity_select = 3'h4;
    logic [7:0]  guard_length = 8'h00;
    logic [15:0] idle_limit = 16'h0000;
    logic        clear_status_cmd = 1'b0;
    logic        send_address_cmd = 1'b0;
    logic        arm_on_next_char_cmd = 1'b0;
    logic        reload_restart_cmd = 1'b0;
    logic        rx_done = 1'b0;
    logic        rx_parity_bit = 1'b0;
    logic        rx_read = 1'b0;
    logic        tx_write = 1'b0;
    logic [7:0]  rx_data = 8'h00;
    logic [7:0]  tx_data = 8'h00;
    logic [7:0]  receive_holding_reg, cap_data, cap_gap, d, g;
    logic        rx_char_ready, overrun_flag, parity_error_flag, timeout_flag;
    logic        tx_holding_free, tx_all_done, tx_line, bit_tick, cap_valid, cap_par, p, a, e;
    logic [2:0]  tm [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    logic [7:0]  q [$];
    int          mismatches = 0;
    int          samples_checked = 0;
    int          seed = 32'h0ead973f;
    int          i, j, k, m, n, t;

    always #4 clk_sys = ~clk_sys;

    usp_core i_dut (.clk_sys(clk_sys), .resetn(resetn), .parity_select(parity_select),
        .guard_length(guard_length), .idle_limit(idle_limit), .clear_status_cmd(clear_status_cmd),
        .send_address_cmd(send_address_cmd), .arm_on_next_char_cmd(arm_on_next_char_cmd),
        .reload_restart_cmd(reload_restart_cmd), .bit_tick(bit_tick), .rx_done(rx_done),
        .rx_data(rx_data), .rx_parity_bit(rx_parity_bit), .rx_read(rx_read), .tx_write(tx_write),
        .tx_data(tx_data), .receive_holding_reg(receive_holding_reg), .rx_char_ready(rx_char_ready),
        .overrun_flag(overrun_flag), .parity_error_flag(parity_error_flag),
        .timeout_flag(timeout_flag), .tx_holding_free(tx_holding_free),
        .tx_all_done(tx_all_done), .tx_line(tx_line));

    usp_remote_model #(.TICK_DIV(TICK_DIV)) i_remote (.clk_sys(clk_sys), .resetn(resetn),
        .parity_select(parity_select), .tx_line(tx_line), .bit_tick(bit_tick),
        .cap_valid(cap_valid), .cap_data(cap_data), .cap_par(cap_par), .cap_gap(cap_gap));

    // Expected receive parity error
    function automatic logic rx_perr(input logic [2:0] md, input logic [7:0] dv, input logic pb);
        case (md)
            3'h0: return pb ^ (^dv);
            3'h1: return pb ~^ (^dv);
            3'h3: return !pb;
            3'h2, 3'h6, 3'h7: return pb;
            default: return 1'b0;
        endcase
    endfunction

    // Expected sent parity bit
    function automatic logic tx_par(input logic [2:0] md, input logic [7:0] dv, input logic am);
        case (md)
            3'h0: return ^dv;
            3'h1: return ~^dv;
            3'h2: return 1'b0;
            3'h3: return 1'b1;
            default: return am;
        endcase
    endfunction

    task automatic chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok)
        begin
            mismatches++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Land just after a tick edge
    task automatic after_tick();
        @(posedge clk_sys);
        for (int w = 0; w < TICK_DIV && !bit_tick; w++)
            @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // One-cycle command, then settle
    task automatic pulse(ref logic s);
        after_tick();
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        @(negedge clk_sys);
    endtask

    // Framer hands over a character
    task automatic rx_char(input logic [7:0] dv, input logic pb);
        after_tick();
        rx_data = dv;
        rx_parity_bit = pb;
        rx_done = 1'b1;
        @(negedge clk_sys);
        rx_done = 1'b0;
        rx_data = ~dv;
        rx_parity_bit = ~pb;
        @(negedge clk_sys);
    endtask

    task automatic tx_put(input logic [7:0] dv);
        tx_data = dv;
        tx_write = 1'b1;
        @(negedge clk_sys);
        tx_write = 1'b0;
        tx_data = ~dv;
    endtask

    task automatic wait_cap();
        int w;
        for (w = 0; w < 400; w++)
        begin
            @(posedge clk_sys);
            #1;
            if (cap_valid)
                break;
        end
        chk(w < 400, "no frame seen");
        @(negedge clk_sys);
    endtask

    // Ticks counted until the time-out flag rises
    task automatic count_ticks(output int c);
        c = 0;
        for (int w = 0; w < 100 * TICK_DIV; w++)
        begin
            @(posedge clk_sys);
            if (bit_tick)
                c++;
            #1;
            if (timeout_flag === 1'b1)
                break;
        end
        @(negedge clk_sys);
    endtask

    initial
    begin
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk({rx_char_ready, overrun_flag, parity_error_flag, timeout_flag} === 4'h0, "reset flags");
        chk(tx_line === 1'b1 && receive_holding_reg === 8'h00 && tx_holding_free === 1'b1, "reset out");
        // Receive in every parity mode
        for (m = 0; m < 8; m++)
        begin
            parity_select = m[2:0];
            for (k = 0; k < 5; k++)
            begin
                d = (k == 0) ? 8'h41 : 8'($random(seed));
                p = (k == 1) ? 1'b1 : 1'($random(seed));
                e = rx_perr(m[2:0], d, p);
                rx_char(d, p);
                chk(rx_char_ready === 1'b1 && receive_holding_reg === d, "held char");
                chk(parity_error_flag === e, "parity check");
                pulse(rx_read);
                chk(rx_char_ready === 1'b0 && parity_error_flag === e, "parity kept");
                pulse(clear_status_cmd);
                chk(parity_error_flag === 1'b0, "parity clear");
            end
        end
        // Overrun survives a read, goes only with clear-status
        rx_char(8'h3c, 1'b0);
        rx_char(8'hc3, 1'b0);
        chk(overrun_flag === 1'b1 && receive_holding_reg === 8'hc3, "overrun");
        pulse(rx_read);
        chk(overrun_flag === 1'b1, "overrun kept");
        pulse(clear_status_cmd);
        chk(overrun_flag === 1'b0, "overrun clear");
        // Transmit in every mode
        for (i = 0; i < 7; i++)
        begin
            parity_select = tm[i];
            for (k = 0; k < 3; k++)
            begin
                d = 8'($random(seed));
                a = (tm[i][2:1] == 2'b11) && (k == 1);
                if (a)
                    pulse(send_address_cmd);
                tx_put(d);
                wait_cap();
                chk(cap_data === d, "tx data");
                if (tm[i][2:1] != 2'b10)
                    chk(cap_par === tx_par(tm[i], d, a), "tx parity");
            end
        end
        // Fill buffer, one write refused, drain
        for (j = 0; j < 2; j++)
        begin
            g = (j == 0) ? 8'h00 : 8'h03;
            guard_length = g;
            tx_put(8'h5a);
            q.push_back(8'h5a);
            repeat (3 * TICK_DIV) @(negedge clk_sys);
            for (n = 0; n < 20 && tx_holding_free === 1'b1; n++)
            begin
                d = 8'($random(seed));
                tx_put(d);
                q.push_back(d);
            end
            chk(n == 16, "buffer depth");
            tx_put(8'h00);
            for (k = 0; k < 17; k++)
            begin
                wait_cap();
                chk(cap_data === q.pop_front(), "buffer order");
                if (k == 0)
                    chk(tx_holding_free === (g == 8'h00), "free during guard");
                else
                    chk(cap_gap >= g && cap_gap <= g + 8'h01, "guard gap");
                if (g != 8'h00 || k < 16)
                    chk(tx_all_done === 1'b0, "all done early");
            end
            e = 1'b0;
            for (n = 0; n < 200 && tx_all_done !== 1'b1; n++)
            begin
                @(posedge clk_sys);
                #1;
                e = e | cap_valid;
            end
            @(negedge clk_sys);
            chk(!e && n < 200 && n + TICK_DIV >= g * TICK_DIV, "drain end");
        end
        // Idle time-out
        pulse(reload_restart_cmd);
        repeat (40 * TICK_DIV) @(negedge clk_sys);
        chk(timeout_flag === 1'b0, "timeout while off");
        idle_limit = 16'h0007;
        pulse(reload_restart_cmd);
        count_ticks(t);
        chk(t == 7, "reload count");
        pulse(reload_restart_cmd);
        chk(timeout_flag === 1'b0, "reload clears");
        count_ticks(t);
        chk(t == 7, "periodic count");
        pulse(arm_on_next_char_cmd);
        chk(timeout_flag === 1'b0, "arm clears");
        repeat (30 * TICK_DIV) @(negedge clk_sys);
        chk(timeout_flag === 1'b0, "armed and idle");
        rx_char(8'h81, 1'b0);
        count_ticks(t);
        chk(t == 7, "count after char");
        report_and_stop();
    end
endmodule
